/* logic/scs_clock_select.sv */
// Function
// RL1: Input strap low: check pin for incoming clock at every enable assertion.
// RL2: Once found, align internal oscillator to rising edges of incoming clock.
// RL3: Source supplies 200 kHz to 1.4 MHz, stable before enable.
// RL4: On clock loss, switch to internal oscillator near last incoming frequency.
// RL5: Open strap auto-detects after enable, synchronising if a clock exists.
// RL6: Auto mode without clock: pin strap low/open/high gives 200k/400k/1M.
// RL7: Pin strap sampled only at start-up; later changes ignored until repower.
// RL8: Resistor on pin maps to frequency through the resistor table.
// RL9: Management writes accepted anywhere from 200 kHz to 1.33 MHz.
// RL10: Valid rates are 8 MHz over N, N from 6 to 40.
// RL11: Non-exact written rate rounds to nearest valid 8 MHz over N.
// RL12: On a shared line one drives out, all others auto-detect.
// RL13: Read-back rate is the quantized hardware value.
// RL14: Output strap: internal 400 kHz driven on pin, pin never checked.
// RL15: Count rising edges in a fixed window after enable to detect clock.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select #(
    parameter int DET_CYCLES = scs_pkg::DET_CYC
) (
    // Clock, reset, clock enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Pins
    input wire logic i_enable,
    input wire logic i_sync_in,
    input wire logic [1:0] i_dir_strap,
    input wire logic [1:0] i_rate_strap,
    input wire logic [4:0] i_rate_res_idx,
    // Management rate write and read-back
    input wire logic i_wr_valid,
    input wire logic [10:0] i_wr_khz,
    output logic [10:0] o_rate_khz,
    // Clock outputs
    output logic o_sw_clk,
    output logic o_sync_out,
    output logic o_sync_oe,
    output logic o_ext_lock
);
    import scs_pkg::*;
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] sy_q;
    logic [1:0] en_sy_q;
    logic [1:0] dir_sy1_q, dir_sy2_q, rate_sy1_q, rate_sy2_q;
    logic [4:0] res_sy1_q, res_sy2_q;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sy_q <= 3'h0;
            en_sy_q <= 2'h0;
            dir_sy1_q <= 2'h0;
            dir_sy2_q <= 2'h0;
            rate_sy1_q <= 2'h0;
            rate_sy2_q <= 2'h0;
            res_sy1_q <= 5'h00;
            res_sy2_q <= 5'h00;
        end
        else if (i_ce)
        begin
            sy_q <= {sy_q[1:0], i_sync_in};
            en_sy_q <= {en_sy_q[0], i_enable};
            dir_sy1_q <= i_dir_strap;
            dir_sy2_q <= dir_sy1_q;
            rate_sy1_q <= i_rate_strap;
            rate_sy2_q <= rate_sy1_q;
            res_sy1_q <= i_rate_res_idx;
            res_sy2_q <= res_sy1_q;
        end
    end
    wire logic rise = sy_q[1] & ~sy_q[2];
    wire logic en_s = en_sy_q[1];
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    scs_state_t state_q, state_d;
    logic [1:0] settle_q, settle_d, dir_q, dir_d, rate_strap_q, rate_strap_d;
    logic taken_q, taken_d, wr_seen_q, wr_seen_d;
    logic [4:0] res_q, res_d;
    logic [5:0] n_q, n_d, n_wr_q, n_wr_d, n_sel, n_near;
    logic [12:0] det_q, det_d;
    logic [1:0] edges_q, edges_d;
    logic [11:0] quiet_q, quiet_d;
    logic [15:0] per_q, per_d, ph_q, ph_d, ph_next;
    logic hold_q, hold_d, sw_q, sw_d;
    logic [10:0] khz_q, khz_d;
    logic out_q, out_d, oe_q, oe_d, lock_q, lock_d;
    always_comb
    begin
        // Nearest divider: pick smallest k whose midpoint the write reaches
        n_near = N_MAX[5:0];
        for (int k = N_MAX - 1; k >= N_MIN; k--)
        begin
            if (int'(i_wr_khz) * 2 * k * (k + 1) >= BASE_KHZ * (2 * k + 1)) // see RL11
                n_near = 6'(k);
        end
        // Rate source for the internal oscillator
        if (dir_q == LVL_HIGH)
            n_sel = N_OUT; // see RL14
        else if (wr_seen_q)
            n_sel = n_wr_q; // see RL9
        else if (dir_q == LVL_OPEN)
        begin
            unique case (rate_strap_q) // see RL6
                LVL_LOW: n_sel = N_LOW;
                LVL_OPEN: n_sel = N_OPEN;
                LVL_HIGH: n_sel = N_HIGH;
                LVL_RES: n_sel = (int'(res_q) < RES_COUNT) ? RES_N[res_q] : N_LOW; // see RL8
            endcase
        end
        else
            n_sel = N_RST;
        khz_d = 11'h000;
        for (int k = N_MIN; k <= N_MAX; k++)
        begin
            if (n_q == 6'(k))
                khz_d = 11'((BASE_KHZ + k / 2) / k); // see RL13
        end
        settle_d = settle_q;
        taken_d = taken_q;
        dir_d = dir_q;
        rate_strap_d = rate_strap_q;
        res_d = res_q;
        // Straps are caught once; only a reset (repower) takes them again
        if (!taken_q)
        begin
            if (settle_q == STRAP_SETTLE)
            begin
                taken_d = 1'b1; // see RL7
                dir_d = dir_sy2_q;
                rate_strap_d = rate_sy2_q;
                res_d = res_sy2_q;
            end
            else
                settle_d = settle_q + 2'h1;
        end
        n_wr_d = n_wr_q;
        wr_seen_d = wr_seen_q;
        if (i_wr_valid)
        begin
            n_wr_d = n_near; // see RL10
            wr_seen_d = 1'b1;
        end
        n_d = n_sel;
        quiet_d = rise ? 12'h000 : ((quiet_q == 12'(LOSS_CYC)) ? quiet_q : quiet_q + 12'h001);
        state_d = state_q;
        det_d = det_q;
        edges_d = edges_q;
        per_d = per_q;
        hold_d = hold_q;
        ph_next = ph_q + QSTEP;
        ph_d = ph_next;
        sw_d = sw_q;
        if (ph_next >= per_q)
        begin
            ph_d = ph_next - per_q;
            sw_d = 1'b1;
        end
        else if (ph_next >= {1'b0, per_q[15:1]})
            sw_d = 1'b0;
        if (rise)
            per_d = {2'h0, quiet_q + 12'h001, 2'h0};
        unique case (state_q)
            ST_OFF:
            begin
                ph_d = 16'h0000;
                sw_d = 1'b0;
                hold_d = 1'b0;
                per_d = per_q;
                det_d = 13'h0000;
                edges_d = 2'h0;
                if (taken_q && en_s)
                    state_d = (dir_q == LVL_HIGH) ? ST_INT : ST_DETECT; // see RL1 RL5 RL14
            end
            ST_DETECT:
            begin
                // Run on the selected rate n_q while listening, so the output never stalls
                per_d = rise ? per_d : 16'(n_q * QPER_PER_N);
                det_d = det_q + 13'h0001;
                if (rise && edges_q != DET_EDGES)
                    edges_d = edges_q + 2'h1; // see RL15
                if (det_q == 13'(DET_CYCLES - 1))
                    state_d = (edges_q == DET_EDGES) ? ST_EXT : ST_INT;
            end
            ST_EXT:
            begin
                if (rise)
                begin
                    ph_d = 16'h0000; // see RL2
                    sw_d = 1'b1;
                end
                else if (quiet_q == 12'(LOSS_CYC - 1))
                begin
                    state_d = ST_INT; // see RL4
                    hold_d = 1'b1;
                end
            end
            ST_INT:
            begin
                per_d = hold_q ? per_q : 16'(n_q * QPER_PER_N); // see RL4
            end
        endcase
        if (!en_s)
            state_d = ST_OFF;
        out_d = (dir_q == LVL_HIGH) ? sw_q : 1'b0;
        oe_d = (dir_q == LVL_HIGH) && (state_q == ST_INT); // see RL14
        lock_d = (state_q == ST_EXT);
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q <= ST_OFF;
            settle_q <= 2'h0;
            taken_q <= 1'b0;
            dir_q <= LVL_LOW;
            rate_strap_q <= LVL_LOW;
            res_q <= 5'h00;
            n_q <= N_RST;
            n_wr_q <= N_RST;
            wr_seen_q <= 1'b0;
            det_q <= 13'h0000;
            edges_q <= 2'h0;
            quiet_q <= 12'h000;
            per_q <= QPER_RST;
            ph_q <= 16'h0000;
            hold_q <= 1'b0;
            sw_q <= 1'b0;
            khz_q <= 11'h000;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            lock_q <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            settle_q <= settle_d;
            taken_q <= taken_d;
            dir_q <= dir_d;
            rate_strap_q <= rate_strap_d;
            res_q <= res_d;
            n_q <= n_d;
            n_wr_q <= n_wr_d;
            wr_seen_q <= wr_seen_d;
            det_q <= det_d;
            edges_q <= edges_d;
            quiet_q <= quiet_d;
            per_q <= per_d;
            ph_q <= ph_d;
            hold_q <= hold_d;
            sw_q <= sw_d;
            khz_q <= khz_d;
            out_q <= out_d;
            oe_q <= oe_d;
            lock_q <= lock_d;
        end
    end
    assign o_rate_khz = khz_q;
    assign o_sw_clk = sw_q;
    assign o_sync_out = out_q;
    assign o_sync_oe = oe_q;
    assign o_ext_lock = lock_q;
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_enable_detect: assert property (@(posedge i_clk) disable iff (i_rst) // see RL1 RL5
        (i_ce && state_q == ST_OFF && en_s && taken_q && dir_q != LVL_HIGH)
        |=> state_q == ST_DETECT) else $error("enable did not start detection");
    a_edge_align: assert property (@(posedge i_clk) disable iff (i_rst) // see RL2
        (i_ce && state_q == ST_EXT && rise && en_s) |=> (sw_q && ph_q == 16'h0000))
        else $error("oscillator not aligned to incoming edge");
    a_loss_fallback: assert property (@(posedge i_clk) disable iff (i_rst) // see RL4
        (i_ce && en_s && state_q == ST_EXT && !rise && quiet_q == 12'(LOSS_CYC - 1))
        |=> (state_q == ST_INT && hold_q && $stable(per_q)))
        else $error("lost clock did not fall back holding period");
    a_auto_rate: assert property (@(posedge i_clk) disable iff (i_rst) // see RL6
        (i_ce && dir_q == LVL_OPEN && !wr_seen_q && rate_strap_q == LVL_LOW)
        |=> n_q == N_LOW) else $error("auto strap low not 200k");
    a_strap_frozen: assert property (@(posedge i_clk) disable iff (i_rst) // see RL7
        ($past(taken_q) && taken_q) |-> ($stable(dir_q) && $stable(rate_strap_q)))
        else $error("strap changed after capture");
    a_n_range: assert property (@(posedge i_clk) disable iff (i_rst) // see RL10
        (n_q >= 6'(N_MIN) && n_q <= 6'(N_MAX))) else $error("divider out of range");
    a_nearest_n: assert property (@(posedge i_clk) disable iff (i_rst) // see RL11
        (i_ce && i_wr_valid && i_wr_khz == 11'h32a) |=> n_wr_q == 6'h0a)
        else $error("810k did not round to N of 10");
    a_readback: assert property (@(posedge i_clk) disable iff (i_rst) // see RL13
        (i_ce && n_q == 6'h14) |=> khz_q == 11'h190) else $error("read-back not 400k");
    a_out_mode: assert property (@(posedge i_clk) disable iff (i_rst) // see RL14
        (dir_q == LVL_HIGH && taken_q) |-> (state_q != ST_DETECT && state_q != ST_EXT))
        else $error("output mode checked the pin");
    a_window_len: assert property (@(posedge i_clk) disable iff (i_rst) // see RL15
        (state_q == ST_DETECT) |-> det_q < 13'(DET_CYCLES)) else $error("window overran");
endmodule : scs_clock_select
`default_nettype wire

/* logic/scs_pkg.sv */
`default_nettype none
package scs_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    // Detection window after enable, in microseconds
    localparam int DET_US = 20;
    localparam int DET_CYC = DET_US * CLK_MHZ;
    // Silence on the pin that counts as a lost clock, in microseconds
    localparam int LOSS_US = 10;
    localparam int LOSS_CYC = LOSS_US * CLK_MHZ;
    // Rising edges needed inside the window to call a clock present
    localparam logic [1:0] DET_EDGES = 2'h3;
    // Strap settle cycles after reset before capture
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ---------------------------------------------------------------
    // Three-level strap encoding (resistor only on the rate strap)
    // ---------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_RES = 2'h3;

    // ---------------------------------------------------------------
    // Divider N of 8 MHz, quarter-cycle period units
    // ---------------------------------------------------------------
    localparam int BASE_KHZ = 8000;
    localparam int N_MIN = 6;
    localparam int N_MAX = 40;
    localparam logic [5:0] N_RST = 6'h14;
    localparam logic [5:0] N_OUT = 6'h14;
    localparam logic [5:0] N_LOW = 6'h28;
    localparam logic [5:0] N_OPEN = 6'h14;
    localparam logic [5:0] N_HIGH = 6'h08;
    // 8 MHz period is 31.25 clocks, i.e. 125 quarter clocks
    localparam logic [15:0] QPER_PER_N = 16'h007d;
    localparam logic [15:0] QSTEP = 16'h0004;
    localparam logic [15:0] QPER_RST = 16'h09c4;
    localparam int RES_COUNT = 19;
    localparam logic [5:0] RES_N [0:RES_COUNT-1] = '{
        6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19, 6'h16, 6'h14, 6'h13, 6'h11,
        6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06
    };

    typedef enum logic [1:0] {ST_OFF, ST_DETECT, ST_EXT, ST_INT} scs_state_t;
endpackage : scs_pkg
`default_nettype wire

/* tb/scs_ext_clock.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_ext_clock #(
    parameter real HALF_NS = 32.0
) (
    // Control
    input wire logic i_run,
    // Pin
    output logic o_pin
);
    // ---------------------------------------------------------------
    // Free clock source, out of phase with the block clock
    // ---------------------------------------------------------------
    // Already running before enable rises; parks low once switched off
    initial
    begin
        o_pin = 1'b0;
        #1.3;
        forever
        begin
            #(HALF_NS);
            o_pin = i_run ? ~o_pin : 1'b0;
        end
    end
endmodule : scs_ext_clock
`default_nettype wire

/* tb/tb_switching_clock_select.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s expected %0d seen %0d", nm, exp, got); end end
module tb_switching_clock_select;
    import scs_pkg::*;
    localparam int DET = 200;
    logic i_clk, i_rst, i_ce, i_enable, i_wr_valid, ext_run, ext_pin, sync_pin;
    logic [1:0] i_dir_strap, i_rate_strap;
    logic [4:0] i_rate_res_idx;
    logic [10:0] i_wr_khz, o_rate_khz;
    logic o_sw_clk, o_sync_out, o_sync_oe, o_ext_lock;
    int mismatches, comparisons;

    // Pin level: own driver wins while enabled, else the far source
    assign sync_pin = o_sync_oe ? o_sync_out : ext_pin;

    scs_ext_clock src_u (.i_run(ext_run), .o_pin(ext_pin));

    scs_clock_select #(.DET_CYCLES(DET)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_enable(i_enable),
        .i_sync_in(sync_pin), .i_dir_strap(i_dir_strap), .i_rate_strap(i_rate_strap),
        .i_rate_res_idx(i_rate_res_idx), .i_wr_valid(i_wr_valid), .i_wr_khz(i_wr_khz),
        .o_rate_khz(o_rate_khz), .o_sw_clk(o_sw_clk), .o_sync_out(o_sync_out),
        .o_sync_oe(o_sync_oe), .o_ext_lock(o_ext_lock));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc

    // Straps are only taken at power-up, so every mode change re-powers
    task automatic power_up(input logic [1:0] dir, input logic [1:0] rate,
                            input logic [4:0] idx);
        i_enable = 1'b0;
        i_dir_strap = dir;
        i_rate_strap = rate;
        i_rate_res_idx = idx;
        i_rst = 1'b1;
        cyc(20);
        i_rst = 1'b0;
        cyc(10);
    endtask : power_up

    task automatic enable_on;
        i_enable = 1'b1;
        cyc(DET + 20);
    endtask : enable_on

    task automatic wait_lvl(input logic lvl, inout int n);
        while (o_sw_clk !== lvl && n < 20000)
        begin
            cyc(1);
            n++;
        end
        if (n >= 20000)
        begin
            mismatches++;
            conclude();
        end
    endtask : wait_lvl

    // Cycles from one rising edge of the switching clock to the next
    task automatic period(output int p);
        int n;
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        p = n;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        p = n - p;
    endtask : period

    task automatic t_strap_rates;
        int p;
        logic [10:0] khz [3] = '{11'h0c8, 11'h190, 11'h3e8};
        int per [3] = '{1250, 625, 250};
        for (int s = 0; s < 3; s++)
        begin
            power_up(LVL_OPEN, s[1:0], 5'h00);
            enable_on();
            `CHK("strap rate", khz[s], o_rate_khz)
            `CHK("no lock", 1'b0, o_ext_lock)
            period(p);
            `CHK("strap period", 1'b1, (p >= per[s] - 1 && p <= per[s] + 1))
        end
    endtask : t_strap_rates

    task automatic t_resistor;
        logic [4:0] idx [4] = '{5'h00, 5'h07, 5'h12, 5'h19};
        logic [10:0] khz [4] = '{11'h0c8, 11'h190, 11'h535, 11'h0c8};
        for (int i = 0; i < 4; i++)
        begin
            power_up(LVL_OPEN, LVL_RES, idx[i]);
            enable_on();
            `CHK("resistor rate", khz[i], o_rate_khz)
        end
    endtask : t_resistor

    task automatic t_strap_late;
        power_up(LVL_OPEN, LVL_HIGH, 5'h00);
        enable_on();
        i_rate_strap = LVL_LOW;
        i_enable = 1'b0;
        cyc(10);
        enable_on();
        `CHK("late strap", 11'h3e8, o_rate_khz)
    endtask : t_strap_late

    task automatic t_ext(input logic [1:0] dir);
        int p;
        power_up(dir, LVL_OPEN, 5'h00);
        ext_run = 1'b1;
        cyc(30);
        enable_on();
        `CHK("ext lock", 1'b1, o_ext_lock)
        `CHK("pin not driven", 1'b0, o_sync_oe)
        `CHK("pin value idle", 1'b0, o_sync_out)
        period(p);
        `CHK("ext period", 16, p)
        ext_run = 1'b0;
        cyc(LOSS_CYC + 100);
        `CHK("lock lost", 1'b0, o_ext_lock)
        period(p);
        `CHK("holdover period", 1'b1, (p >= 15 && p <= 17))
        i_enable = 1'b0;
        cyc(10);
        ext_run = 1'b1;
        cyc(30);
        enable_on();
        `CHK("relock", 1'b1, o_ext_lock)
        ext_run = 1'b0;
    endtask : t_ext

    task automatic t_output;
        int p;
        power_up(LVL_HIGH, LVL_HIGH, 5'h00);
        enable_on();
        `CHK("drives pin", 1'b1, o_sync_oe)
        `CHK("never locks", 1'b0, o_ext_lock)
        `CHK("out rate", 11'h190, o_rate_khz)
        period(p);
        `CHK("out period", 1'b1, (p >= 624 && p <= 626))
        // Pin copy trails the switching clock by one cycle
        `CHK("sync out lags", 1'b0, o_sync_out)
        cyc(1);
        `CHK("sync out", 1'b1, o_sync_out)
        // Clock enable low must freeze the oscillator mid high phase
        i_ce = 1'b0;
        cyc(400);
        `CHK("frozen clock", 1'b1, o_sw_clk)
        `CHK("frozen oe", 1'b1, o_sync_oe)
        i_ce = 1'b1;
        cyc(1);
    endtask : t_output

    task automatic t_write;
        logic [10:0] wr [7] = '{11'h32a, 11'h532, 11'h0c8, 11'h2bc, 11'h280, 11'h7d0, 11'h032};
        logic [10:0] exp [7] = '{11'h320, 11'h535, 11'h0c8, 11'h2d7, 11'h267, 11'h535, 11'h0c8};
        power_up(LVL_LOW, LVL_OPEN, 5'h00);
        enable_on();
        `CHK("input idle rate", 11'h190, o_rate_khz)
        for (int i = 0; i < 7; i++)
        begin
            i_wr_valid = 1'b1;
            i_wr_khz = wr[i];
            cyc(1);
            i_wr_valid = 1'b0;
            cyc(6);
            `CHK("written rate", exp[i], o_rate_khz)
        end
    endtask : t_write

    // ---------------------------------------------------------------
    // Clock, time limit and main sequence
    // ---------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever
            #2 i_clk = ~i_clk;
    end

    initial
    begin
        #400000;
        mismatches++;
        conclude();
    end

    initial
    begin
        mismatches = 0;
        comparisons = 0;
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_enable = 1'b0;
        i_wr_valid = 1'b0;
        i_wr_khz = 11'h000;
        ext_run = 1'b0;
        i_dir_strap = LVL_OPEN;
        i_rate_strap = LVL_OPEN;
        i_rate_res_idx = 5'h00;
        t_strap_rates();
        t_resistor();
        t_strap_late();
        t_ext(LVL_LOW);
        t_ext(LVL_OPEN);
        t_output();
        t_write();
        conclude();
    end
endmodule : tb_switching_clock_select
`default_nettype wire
